/* File: pkg/fhp_pkg.sv */
// Constants and carriers for the flash header parser and protection checker.
// Assumes a byte-wide flash read port and a single pclk domain.
package fhp_pkg;
   localparam int ADDR_W = 18;
   localparam int SECTOR_COUNT = 256;
   localparam int SECTOR_BYTES = 1024;
   localparam int SECTOR_SHIFT = 10;
   localparam logic [ADDR_W-1:0] HDR_BASE = 18'h00000;
   localparam logic [ADDR_W-1:0] HDR_LAST = 18'h00016;
   localparam logic [ADDR_W-1:0] HDR_CFG = 18'h00000;
   localparam logic [ADDR_W-1:0] HDR_PTR_LO = 18'h00003;
   localparam logic [ADDR_W-1:0] HDR_PTR_HI = 18'h00004;
   localparam logic [ADDR_W-1:0] HDR_SYS0 = 18'h00005;
   localparam logic [ADDR_W-1:0] HDR_CUSTOM = 18'h00017;
   localparam int ENTRY_BYTES = 6;
   localparam int SYS_MACROS = 3;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [4:0] CFG_PATTERN = 5'h19;
   localparam int BIT_READ_GUARD = 2;
   localparam int BIT_WRITE_GUARD = 1;
   localparam int BIT_CHIP_ERASE_GUARD = 0;
   localparam logic [7:0] CFG_RESET = 8'hcf;
   localparam int FLASH_LATENCY = 1;
   // APB map
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h04;
   localparam logic [7:0] REG_PTR = 8'h08;
   localparam logic [7:0] REG_SLOT_IDX = 8'h0c;
   localparam logic [7:0] REG_SLOT_START = 8'h10;
   localparam logic [7:0] REG_SLOT_END = 8'h14;
   localparam logic [7:0] REG_CMD_ADDR = 8'h18;
   localparam logic [7:0] REG_CMD = 8'h1c;
   localparam logic [7:0] REG_CUSTOM_BASE = 8'h20;
   localparam logic [7:0] REG_SYS_EMPTY = 8'h24;
   localparam int ST_READY = 0;
   localparam int ST_ERR = 1;
   localparam int ST_ACCEPT = 2;
   localparam int ST_REFUSE = 3;
   typedef enum logic [2:0] {
      FHP_OP_READ, FHP_OP_PLAY, FHP_OP_WRITE, FHP_OP_SECTOR_ERASE, FHP_OP_CHIP_ERASE
   } fhp_op_e;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } fhp_apb_req_s;
   typedef struct packed {
      logic [23:0] start_addr;
      logic [23:0] end_addr;
   } fhp_entry_s;
endpackage

/* File: logic/fhp_slot_mem.sv */
// Small memory for the three system macro index entries.
// Assumes one writer and one reader on pclk; read data are registered.
`timescale 1ns/1ps
module fhp_slot_mem import fhp_pkg::*; #(
   parameter int DEPTH = 3
) (
   // Clock
   input wire logic pclk,
   // Write side
   input wire logic wr_en,
   input wire logic [1:0] wr_idx,
   input wire logic [2:0] wr_byte,
   input wire logic [7:0] wr_data,
   // Read side
   input wire logic [1:0] rd_idx,
   output fhp_entry_s rd_data
);
   logic [7:0] mem [DEPTH][ENTRY_BYTES];

   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_idx][wr_byte] <= wr_data;
      end
   end

   // Start from bytes 0..2, end from 3..5, each low byte first
   always_ff @(posedge pclk) begin
      rd_data <= {mem[rd_idx][2], mem[rd_idx][1], mem[rd_idx][0],
                  mem[rd_idx][5], mem[rd_idx][4], mem[rd_idx][3]};
   end
endmodule // fhp_slot_mem

/* File: logic/fhp_top.sv */
// Flash header parser and protection checker with an APB register slave.
// Assumes a flash byte read port with fixed one-cycle latency on pclk.
// Behaviour
// - Flash is 256 sectors of 1024 bytes; sector is address over 1024.
// - Header is fetched from byte address zero after reset.
// - Header of at least 23 bytes (0x00 to 0x16) is expected at memory start.
// - Byte 0 is protection config; bytes 3 and 4 the pointer.
// - Multi-byte fields assemble least significant byte first.
// - From byte 5 each index entry is three-byte start, three-byte end.
// - Three system macro slots sit at bytes 0x05 to 0x16 in order.
// - A system slot of all ones is an empty macro.
// - Custom macro entries start at 0x17; prompt entries follow, six bytes each.
// - Without user data, prompt then macro data follow contiguously.
// - Locations past the image read as erased all-ones bytes.
// - Protected region runs from zero to end of the pointer's sector.
// - Config bits 7:3 are 11001; bits 2,1,0 guard read, write, erase.
// - Chip-erase guard refuses mass erase, sector erase still allowed.
// - Write guard refuses writes and sector erases in protected region.
// - Write guard alone still allows mass erase.
// - Read guard refuses protected reads and playback and sets error.
// - 0xCF means no protection; 0xC8 means all three guards.
// - Protection loads at power-up; edits apply after next chip reset.
// - Macro indices 0 to 2 are system; custom macros start at 3.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module fhp_top import fhp_pkg::*; #(
   parameter int ADDR_WIDTH = ADDR_W
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash read port
   output logic flash_rd_en,
   output logic [ADDR_WIDTH-1:0] flash_rd_addr,
   input wire logic [7:0] flash_rd_data,
   // Checked command out to the flash sequencer
   output logic cmd_go,
   output logic [2:0] cmd_op,
   output logic [ADDR_WIDTH-1:0] cmd_addr,
   output logic header_ready
);
   typedef enum logic [1:0] {FHP_FETCH, FHP_WAIT, FHP_DONE} fhp_state_e;

   fhp_state_e state_q;
   logic [ADDR_WIDTH-1:0] fetch_addr_q;
   logic [ADDR_WIDTH-1:0] got_addr_q;
   logic got_valid_q;
   logic [7:0] protection_config_byte_q;
   logic [15:0] protected_memory_pointer_q;
   logic [2:0] sys_empty_q;
   logic [1:0] slot_idx_q;
   logic [ADDR_WIDTH-1:0] cmd_addr_q;
   logic error_q;
   logic accept_q;
   logic refuse_q;
   logic cmd_valid_q;
   fhp_op_e cmd_op_q;
   fhp_entry_s slot_rd;
   logic slot_wr_en;
   logic [1:0] slot_wr_idx;
   logic [2:0] slot_wr_byte;
   logic [ADDR_WIDTH-1:0] slot_off;
   logic apb_acc;
   logic apb_wr;
   logic read_guard;
   logic write_guard;
   logic chip_erase_guard;
   logic cfg_valid;
   logic refuse;
   fhp_op_e new_op;
   logic cmd_addr_wr;
   logic slot_idx_wr;
   logic cmd_wr;
   logic status_wr;

   // Sector number of a byte address
   function automatic logic [7:0] sector_of(input logic [ADDR_WIDTH-1:0] a);
      sector_of = a[SECTOR_SHIFT +: 8];
   endfunction

   // Inside zero through end of pointer's sector
   function automatic logic in_protected(input logic [ADDR_WIDTH-1:0] a,
                                         input logic [15:0] ptr);
      logic [ADDR_WIDTH-1:0] p;
      p = {{(ADDR_WIDTH-16){1'b0}}, ptr};
      in_protected = sector_of(a) <= sector_of(p);
   endfunction

   // Write strobe for one register offset
   function automatic logic reg_write(input logic wr, input logic [7:0] a,
                                      input logic [7:0] off);
      reg_write = wr && a == off;
   endfunction

   // Offsets that hold a register; the rest answer with an error
   function automatic logic reg_mapped(input logic [7:0] a);
      case (a)
         REG_STATUS, REG_CFG, REG_PTR, REG_SLOT_IDX, REG_SLOT_START,
         REG_SLOT_END, REG_CMD_ADDR, REG_CMD, REG_CUSTOM_BASE,
         REG_SYS_EMPTY: reg_mapped = 1'b1;
         default: reg_mapped = 1'b0;
      endcase
   endfunction

   // Writes land on the edge where pready is high, never earlier
   assign apb_acc = psel && penable;
   assign apb_wr = apb_acc && pwrite && pready && reg_mapped(paddr);
   assign cmd_addr_wr = reg_write(apb_wr, paddr, REG_CMD_ADDR);
   assign slot_idx_wr = reg_write(apb_wr, paddr, REG_SLOT_IDX);
   assign cmd_wr = reg_write(apb_wr, paddr, REG_CMD) && header_ready;
   assign status_wr = reg_write(apb_wr, paddr, REG_STATUS);

   // Header fetch: one address out per two cycles, bytes 0x00..0x16
   // Stops after the last system slot; custom and prompt entries are not read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= FHP_FETCH;
         fetch_addr_q <= HDR_BASE;
      end else begin
         case (state_q)
            FHP_FETCH: begin
               state_q <= FHP_WAIT;
            end
            FHP_WAIT: begin
               if (fetch_addr_q == HDR_LAST) begin
                  state_q <= FHP_DONE;
               end else begin
                  fetch_addr_q <= fetch_addr_q + 1'b1;
                  state_q <= FHP_FETCH;
               end
            end
            FHP_DONE: begin
               state_q <= FHP_DONE;
            end
            default: begin
               state_q <= FHP_FETCH;
            end
         endcase
      end
   end

   // Read strobe and address leave from flops, so the flash sees clean edges
   // Ready stays up until the next reset; nothing else clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_rd_en <= 1'b0;
         flash_rd_addr <= '0;
         header_ready <= 1'b0;
      end else begin
         flash_rd_en <= (state_q == FHP_FETCH);
         flash_rd_addr <= fetch_addr_q;
         header_ready <= (state_q == FHP_DONE);
      end
   end

   // Returned byte tagged with its address
   // Fixed one-cycle latency lets the sent address name the byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         got_valid_q <= 1'b0;
         got_addr_q <= '0;
      end else begin
         got_valid_q <= flash_rd_en;
         got_addr_q <= flash_rd_addr;
      end
   end

   // Latched only during the reset-time fetch, so later edits wait for reset
   // Pointer bytes arrive low first, so each half has its own slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         protection_config_byte_q <= CFG_RESET;
         protected_memory_pointer_q <= '0;
      end else if (got_valid_q && state_q != FHP_DONE) begin
         if (got_addr_q == HDR_CFG) begin
            protection_config_byte_q <= flash_rd_data;
         end
         if (got_addr_q == HDR_PTR_LO) begin
            protected_memory_pointer_q[7:0] <= flash_rd_data;
         end
         if (got_addr_q == HDR_PTR_HI) begin
            protected_memory_pointer_q[15:8] <= flash_rd_data;
         end
      end
   end

   // System slots: bytes 0x05..0x16, six per slot
   assign slot_off = got_addr_q - HDR_SYS0;
   assign slot_wr_en = got_valid_q && got_addr_q >= HDR_SYS0 && got_addr_q <= HDR_LAST;
   assign slot_wr_idx = slot_off[4:0] < 5'd6 ? 2'd0 : (slot_off[4:0] < 5'd12 ? 2'd1 : 2'd2);
   assign slot_wr_byte = 3'(slot_off[4:0] - 5'(32'(slot_wr_idx) * ENTRY_BYTES));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_empty_q <= '1;
      end else if (slot_wr_en && flash_rd_data != ERASED_BYTE) begin
         sys_empty_q[slot_wr_idx] <= 1'b0;
      end
   end

   fhp_slot_mem #(.DEPTH(SYS_MACROS)) u_slots (
      .pclk(pclk),
      .wr_en(slot_wr_en),
      .wr_idx(slot_wr_idx),
      .wr_byte(slot_wr_byte),
      .wr_data(flash_rd_data),
      .rd_idx(slot_idx_q),
      .rd_data(slot_rd)
   );

   // Guards active low; wrong pattern falls back to all guards on
   // Only the latched copy is consulted, never the flash itself
   assign cfg_valid = protection_config_byte_q[7:3] == CFG_PATTERN;
   assign read_guard = !cfg_valid || !protection_config_byte_q[BIT_READ_GUARD];
   assign write_guard = !cfg_valid || !protection_config_byte_q[BIT_WRITE_GUARD];
   assign chip_erase_guard = !cfg_valid || !protection_config_byte_q[BIT_CHIP_ERASE_GUARD];
   assign new_op = fhp_op_e'(pwdata[2:0]);

   always_comb begin
      case (new_op)
         FHP_OP_READ, FHP_OP_PLAY:
            refuse = read_guard && in_protected(cmd_addr_q, protected_memory_pointer_q);
         FHP_OP_WRITE, FHP_OP_SECTOR_ERASE:
            refuse = write_guard && in_protected(cmd_addr_q, protected_memory_pointer_q);
         FHP_OP_CHIP_ERASE:
            refuse = chip_erase_guard;
         default:
            refuse = 1'b1;
      endcase
   end

   // Command address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_addr_q <= '0;
      end else if (cmd_addr_wr) begin
         cmd_addr_q <= pwdata[ADDR_WIDTH-1:0];
      end
   end

   // Slot index from pwdata[1:0]; a value of 3 there, past the last slot, leaves the index alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_idx_q <= '0;
      end else if (slot_idx_wr && pwdata[1:0] < 2'(SYS_MACROS)) begin
         slot_idx_q <= pwdata[1:0];
      end
   end

   // Command check; only issued once header is parsed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_valid_q <= 1'b0;
         cmd_op_q <= FHP_OP_READ;
         accept_q <= 1'b0;
         refuse_q <= 1'b0;
      end else begin
         cmd_valid_q <= 1'b0;
         if (cmd_wr) begin
            cmd_op_q <= new_op;
            cmd_valid_q <= !refuse;
            accept_q <= !refuse;
            refuse_q <= refuse;
         end
      end
   end

   // Error flag: set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_q <= 1'b0;
      end else if (cmd_wr && refuse &&
                   (new_op == FHP_OP_READ || new_op == FHP_OP_PLAY)) begin
         error_q <= 1'b1;
      end else if (status_wr && pwdata[ST_ERR]) begin
         error_q <= 1'b0;
      end
   end

   // Checked command goes out one cycle after the check, as a single pulse
   // Op and address follow cmd_op_q and cmd_addr_q between pulses; only cmd_go marks a new one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_go <= 1'b0;
         cmd_op <= '0;
         cmd_addr <= '0;
      end else begin
         cmd_go <= cmd_valid_q;
         cmd_op <= cmd_op_q;
         cmd_addr <= cmd_addr_q;
      end
   end

   // APB: one wait state so slot memory read data settle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= apb_acc && !pready;
      end
   end

   // Unmapped offsets answer with an error and ignore writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= apb_acc && !pready && !reg_mapped(paddr);
      end
   end

   // Read data stand for the single pready cycle, zero otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else begin
         prdata <= '0;
         if (apb_acc && !pready) begin
            case (paddr)
               REG_STATUS:
                  prdata <= {28'h0000000, refuse_q, accept_q, error_q, header_ready};
               REG_CFG: prdata <= {24'h000000, protection_config_byte_q};
               REG_PTR: prdata <= {16'h0000, protected_memory_pointer_q};
               REG_SLOT_IDX: prdata <= {30'h00000000, slot_idx_q};
               // Entry addresses pass as stored; contiguous data need no offset
               REG_SLOT_START: prdata <= {8'h00, slot_rd.start_addr};
               REG_SLOT_END: prdata <= {8'h00, slot_rd.end_addr};
               REG_CMD_ADDR: prdata <= {{(32-ADDR_WIDTH){1'b0}}, cmd_addr_q};
               REG_CMD: prdata <= {29'h00000000, cmd_op_q};
               REG_CUSTOM_BASE: prdata <= {{(32-ADDR_WIDTH){1'b0}}, HDR_CUSTOM};
               REG_SYS_EMPTY: prdata <= {29'h00000000, sys_empty_q};
               default: prdata <= '0;
            endcase
         end
      end
   end
endmodule // fhp_top

/* File: tb/fhp_top_checker.sv */
// Checks on the header fetch, APB timing and command issue of fhp_top.
// Assumes one pclk domain with async active-low presetn; bound below.
`timescale 1ns/1ps
module fhp_top_checker import fhp_pkg::*; #(
   parameter int ADDR_WIDTH = ADDR_W
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // Flash fetch and command
   input wire logic flash_rd_en,
   input wire logic [ADDR_WIDTH-1:0] flash_rd_addr,
   input wire logic cmd_go,
   input wire logic [2:0] cmd_op,
   input wire logic header_ready
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic seen_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         seen_q <= 1'b0;
      else if (flash_rd_en)
         seen_q <= 1'b1;
   end
   sequence s_next_byte;
      !flash_rd_en ##1 (flash_rd_en && flash_rd_addr == $past(flash_rd_addr, 2) + 1'b1);
   endsequence
   sequence s_cmd_write;
      psel && penable && pready && pwrite && paddr == REG_CMD;
   endsequence
   property p_first_addr;
      flash_rd_en && !seen_q |-> flash_rd_addr == HDR_BASE;
   endproperty
   a_first_addr: assert property (p_first_addr)
      else $error("first header read not at address zero");
   property p_hdr_range;
      flash_rd_en |-> flash_rd_addr <= HDR_LAST;
   endproperty
   a_hdr_range: assert property (p_hdr_range)
      else $error("header read outside header bytes");
   property p_seq;
      flash_rd_en && flash_rd_addr < HDR_LAST |=> s_next_byte;
   endproperty
   a_seq: assert property (p_seq)
      else $error("header bytes not fetched in order");
   property p_hdr_done;
      $rose(presetn) |-> ##[1:100] header_ready;
   endproperty
   a_hdr_done: assert property (p_hdr_done)
      else $error("header fetch did not finish");
   property p_ready_keep;
      header_ready |=> header_ready && !flash_rd_en;
   endproperty
   a_ready_keep: assert property (p_ready_keep)
      else $error("header dropped or refetched without reset");
   property p_no_reread;
      header_ready |-> !flash_rd_en;
   endproperty
   a_no_reread: assert property (p_no_reread)
      else $error("flash read after header latched");
   property p_pready_ws;
      $rose(penable) && psel |=> pready ##1 !pready;
   endproperty
   a_pready_ws: assert property (p_pready_ws)
      else $error("pready not a single pulse after one wait state");
   property p_cmd_cause;
      cmd_go |-> header_ready && $past(pwdata[2:0], 2) == cmd_op &&
         $past(psel && penable && pready && pwrite && paddr == REG_CMD, 2);
   endproperty
   a_cmd_cause: assert property (p_cmd_cause)
      else $error("command issued without matching command write");
   property p_cmd_op;
      s_cmd_write ##2 cmd_go |-> cmd_op == $past(pwdata[2:0], 2);
   endproperty
   a_cmd_op: assert property (p_cmd_op)
      else $error("issued command code differs from the one written");
endmodule // fhp_top_checker

bind fhp_top fhp_top_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .flash_rd_en(flash_rd_en),
   .flash_rd_addr(flash_rd_addr), .cmd_go(cmd_go), .cmd_op(cmd_op),
   .header_ready(header_ready)
);

/* File: tb/fhp_flash_model.sv */
// Behavioural flash byte-read port that answers the header fetch.
// Assumes one-cycle read latency; the bench loads the image into mem.
`timescale 1ns/1ps
module fhp_flash_model import fhp_pkg::*; (
   // Clock
   input wire logic pclk,
   // Read port
   input wire logic rd_en,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [7:0] rd_data
);
   // Image starts at byte zero
   logic [7:0] mem [0:63];
   initial begin
      rd_data = 8'h00;
      foreach (mem[i]) mem[i] = ERASED_BYTE;
   end
   // Outside the latency slot the line scrambles, never holds the byte
   always @(posedge pclk) begin
      if (rd_en === 1'b1 && rd_addr < 18'h40)
         rd_data <= mem[rd_addr[5:0]];
      else if (rd_en === 1'b1)
         rd_data <= ERASED_BYTE;
      else
         rd_data <= ~rd_data;
   end
endmodule // fhp_flash_model

/* File: tb/fhp_top_tb.sv */
// Self-checking bench for fhp_top: header readback and guarded commands.
// Assumes the flash model and checker are compiled before this file.
`timescale 1ns/1ps
module fhp_top_tb import fhp_pkg::*;;
   localparam logic [15:0] PTR = 16'h0c05;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fen, cmd_go, hdr_rdy, er;
   logic [7:0] paddr, frd;
   logic [31:0] pwdata, prdata, rd;
   logic [ADDR_W-1:0] faddr, cmd_addr;
   logic [2:0] cmd_op;
   logic [20:0] go_q;
   int bad_count = 0;
   int checks_done = 0;
   int go_cnt = 0;
   fhp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_rd_en(fen), .flash_rd_addr(faddr), .flash_rd_data(frd),
      .cmd_go(cmd_go), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .header_ready(hdr_rdy));
   fhp_flash_model flash (.pclk(pclk), .rd_en(fen), .rd_addr(faddr), .rd_data(frd));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (cmd_go === 1'b1) begin
         go_cnt++;
         go_q = {cmd_op, cmd_addr};
      end
   end
   task automatic test_done();
      $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check(32'(n < 16), 32'h1);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic boot(input logic [7:0] cfg);
      int n;
      n = 0;
      flash.mem[0] = cfg;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      while (hdr_rdy !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      check(32'(hdr_rdy), 32'h1);
      rdchk(REG_CFG, 32'(cfg));
   endtask
   task automatic cmd(input logic [2:0] op, input logic [17:0] a, input logic [7:0] cfg);
      logic prot, rf;
      int g;
      prot = (a >> 10) <= 18'(PTR >> 10);
      rf = (op == 3'h4 && !cfg[0]) || ((op == 3'h2 || op == 3'h3) && !cfg[1] && prot)
         || (op < 3'h2 && !cfg[2] && prot) || op > 3'h4;
      g = go_cnt;
      apb(1'b1, REG_CMD_ADDR, 32'(a));
      apb(1'b1, REG_CMD, 32'(op));
      repeat (4) @(posedge pclk);
      check(32'(go_cnt - g), 32'(!rf));
      if (!rf) check(32'(go_q), 32'({op, a}));
      apb(1'b0, REG_STATUS, 32'h0);
      check(rd & 32'hf, {28'h0, rf, !rf, rf && op < 3'h2, 1'b1});
      apb(1'b1, REG_STATUS, 32'he);
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      #1;
      for (int i = 1; i < 23; i++) flash.mem[i] = 8'(8'h30 + i);
      for (int i = 11; i < 17; i++) flash.mem[i] = 8'hff;
      flash.mem[3] = PTR[7:0];
      flash.mem[4] = PTR[15:8];
      boot(8'hc8);
      rdchk(REG_PTR, 32'(PTR));
      rdchk(REG_CUSTOM_BASE, 32'h17);
      rdchk(REG_SYS_EMPTY, 32'h2);
      apb(1'b1, REG_SLOT_IDX, 32'h2);
      rdchk(REG_SLOT_START, 32'h434241);
      rdchk(REG_SLOT_END, 32'h464544);
      apb(1'b1, REG_SLOT_IDX, 32'h0);
      rdchk(REG_SLOT_END, 32'h3a3938);
      apb(1'b0, 8'h80, 32'h0);
      check(32'(er), 32'h1);
      for (int c = 8; c < 16; c++) begin
         if (c > 8) begin
            // Stored byte changes now, latched guards must not
            flash.mem[0] = 8'(8'hc0 + c);
            cmd(3'h4, 18'h1000, 8'(8'hc0 + c - 1));
            boot(8'(8'hc0 + c));
         end
         for (int o = 0; o < 5; o++) begin
            cmd(3'(o), 18'h0fff, 8'(8'hc0 + c));
            cmd(3'(o), 18'h1000, 8'(8'hc0 + c));
         end
      end
      // Bad pattern in bits 7:3 must fall back to every guard on
      boot(8'h0f);
      cmd(3'h4, 18'h1000, 8'hc8);
      cmd(3'h1, 18'h0fff, 8'hc8);
      cmd(3'h5, 18'h1000, 8'hc8);
      test_done();
   end
   initial begin
      repeat (40000) @(posedge pclk);
      bad_count++;
      test_done();
   end
endmodule // fhp_top_tb
